// [core/ttsi_exec.sv]
`timescale 1ns/1ps
`include "ttsi_params.svh"
module ttsi_exec (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // decoded instruction
  input  wire logic        op_valid_in,
  input  wire logic [3:0]  op_code_in,
  input  wire logic [1:0]  bit_sel_in,
  input  wire logic [1:0]  index_y_in,
  // core registers
  input  wire logic [3:0]  acc_in,
  input  wire logic [3:0]  reg_b_in,
  input  wire logic [3:0]  mem_word_in,
  input  wire logic [7:0]  timer2_count_in,
  // port d pins
  input  wire logic [3:0]  portd_pins_in,
  // register writes
  output logic             acc_we_out,
  output logic [3:0]       acc_out,
  output logic             reg_b_we_out,
  output logic [3:0]       reg_b_out,
  // timer 1
  output logic             timer1_count_we_out,
  output logic [7:0]       timer1_count_out,
  output logic [7:0]       timer1_first_reload_out,
  output logic [7:0]       timer1_second_reload_out,
  // timer 2
  output logic             timer2_count_we_out,
  output logic [7:0]       timer2_count_out,
  output logic [7:0]       timer2_first_reload_out,
  output logic [7:0]       timer2_second_reload_out,
  // sequencing
  output logic             skip_next_out,
  output logic             busy_out,
  // serial
  output logic             serial_start_out,
  output logic             serial_request_flag_clr_out
);
  ////////////////////////////////////////////////////////////////////////
  logic [3:0] portd_sync;
  ttsi_sync2 u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (portd_pins_in),
    .q_out    (portd_sync)
  );

  ttsi_pkg::ttsi_state_type state_reg;
  ttsi_pkg::ttsi_state_type state_next;
  logic [1:0] portd_idx_reg;
  logic [1:0] cyc_cnt_reg;

  wire idle = (state_reg == ttsi_pkg::ST_IDLE);
  wire go   = op_valid_in && idle;
  wire is_t1_low  = go && op_code_in == ttsi_pkg::OP_LOAD_T1_LOW;
  wire is_t1_high = go && op_code_in == ttsi_pkg::OP_LOAD_T1_HIGH;
  wire is_t1_rel  = go && op_code_in == ttsi_pkg::OP_RELOAD_T1;
  wire is_t2_low  = go && op_code_in == ttsi_pkg::OP_LOAD_T2_LOW;
  wire is_t2_high = go && op_code_in == ttsi_pkg::OP_LOAD_T2_HIGH;
  wire is_t2_rel  = go && op_code_in == ttsi_pkg::OP_RELOAD_T2;
  wire is_tab     = go && op_code_in == ttsi_pkg::OP_B_TO_ACC;
  wire is_t2_rd   = go && op_code_in == ttsi_pkg::OP_READ_T2;
  wire is_szb     = go && op_code_in == ttsi_pkg::OP_SKIP_MEM_BIT;
  wire is_szd     = go && op_code_in == ttsi_pkg::OP_SKIP_PORTD_BIT;
  wire is_sst     = go && op_code_in == ttsi_pkg::OP_SERIAL_START;

  wire [7:0] ba_byte   = {reg_b_in, acc_in};
  wire       mem_zero  = ~mem_word_in[bit_sel_in];
  wire       portd_zero = ~portd_sync[portd_idx_reg];
  wire       portd_done = !idle && cyc_cnt_reg == `TTSI_PORTD_CYCLES - 2'h1;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ttsi_pkg::ST_IDLE:  if (is_szd) state_next = ttsi_pkg::ST_PORTD;
      ttsi_pkg::ST_PORTD: if (portd_done) state_next = ttsi_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg     <= ttsi_pkg::ST_IDLE;
      portd_idx_reg <= 2'h0;
      cyc_cnt_reg   <= 2'h0;
    end else begin
      state_reg     <= state_next;
      cyc_cnt_reg   <= is_szd ? 2'h1 : cyc_cnt_reg + 2'h1;
      if (is_szd) portd_idx_reg <= index_y_in;
    end
  end

  // reload registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer1_first_reload_out  <= `TTSI_BYTE_RST;
      timer1_second_reload_out <= `TTSI_BYTE_RST;
      timer2_first_reload_out  <= `TTSI_BYTE_RST;
      timer2_second_reload_out <= `TTSI_BYTE_RST;
    end else begin
      if (is_t1_low)  timer1_first_reload_out  <= ba_byte;
      if (is_t1_high) timer1_second_reload_out <= ba_byte;
      if (is_t2_low)  timer2_first_reload_out  <= ba_byte;
      if (is_t2_high) timer2_second_reload_out <= ba_byte;
    end
  end

  // counter write strobes, one cycle each
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer1_count_we_out <= 1'b0;
      timer1_count_out    <= `TTSI_BYTE_RST;
      timer2_count_we_out <= 1'b0;
      timer2_count_out    <= `TTSI_BYTE_RST;
    end else begin
      timer1_count_we_out <= is_t1_low || is_t1_rel;
      timer2_count_we_out <= is_t2_low || is_t2_rel;
      if (is_t1_low) timer1_count_out <= ba_byte;
      else if (is_t1_rel) timer1_count_out <= timer1_first_reload_out;
      if (is_t2_low) timer2_count_out <= ba_byte;
      else if (is_t2_rel) timer2_count_out <= timer2_first_reload_out;
    end
  end

  // accumulator / b writeback; timer read samples the live counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_we_out   <= 1'b0;
      acc_out      <= `TTSI_NIB_RST;
      reg_b_we_out <= 1'b0;
      reg_b_out    <= `TTSI_NIB_RST;
    end else begin
      acc_we_out   <= is_tab || is_t2_rd;
      reg_b_we_out <= is_t2_rd;
      if (is_tab) acc_out <= reg_b_in;
      else if (is_t2_rd)
        acc_out <= timer2_count_in[`TTSI_LO_MSB:`TTSI_LO_LSB];
      if (is_t2_rd)
        reg_b_out <= timer2_count_in[`TTSI_HI_MSB:`TTSI_HI_LSB];
    end
  end

  // skip, busy and serial strobes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      skip_next_out               <= 1'b0;
      busy_out                    <= 1'b0;
      serial_start_out            <= 1'b0;
      serial_request_flag_clr_out <= 1'b0;
    end else begin
      skip_next_out <= (is_szb && mem_zero) || (portd_done && portd_zero);
      busy_out      <= state_next == ttsi_pkg::ST_PORTD;
      serial_start_out            <= is_sst;
      serial_request_flag_clr_out <= is_sst;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_t1_high_load: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_t1_high |=> timer1_second_reload_out == $past(ba_byte)
                   && !timer1_count_we_out)
    else $error("timer1 second reload not loaded");

  a_t1_reload_copy: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_t1_rel |=> timer1_count_we_out
                  && timer1_count_out == $past(timer1_first_reload_out))
    else $error("timer1 reload copy wrong");

  a_t2_low_load: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_t2_low |=> timer2_count_out == $past(ba_byte)
                  && timer2_first_reload_out == $past(ba_byte))
    else $error("timer2 low load wrong");

  a_t2_high_load: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_t2_high |=> timer2_second_reload_out == $past(ba_byte)
                   && !timer2_count_we_out)
    else $error("timer2 second reload not loaded");

  a_t2_reload_copy: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_t2_rel |=> timer2_count_we_out
                  && timer2_count_out == $past(timer2_first_reload_out))
    else $error("timer2 reload copy wrong");

  a_b_to_acc: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_tab |=> acc_we_out && !reg_b_we_out && acc_out == $past(reg_b_in))
    else $error("b to acc transfer wrong");

  a_t2_read: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_t2_rd |=> {reg_b_out, acc_out} == $past(timer2_count_in))
    else $error("timer2 read wrong");

  a_mem_skip: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_szb |=> skip_next_out == $past(mem_zero))
    else $error("memory bit skip wrong");

  sequence s_portd_start;
    is_szd;
  endsequence
  a_portd_two_cyc: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    s_portd_start |=> busy_out ##1 !busy_out)
    else $error("port d test not two cycles");

  a_t1_low_load: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_t1_low |=> timer1_count_out == $past(ba_byte)
                  && timer1_first_reload_out == $past(ba_byte))
    else $error("timer1 low load wrong");

  a_serial_start: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_sst |=> serial_start_out && serial_request_flag_clr_out)
    else $error("serial start strobes missing");
endmodule : ttsi_exec

// [core/ttsi_params.svh]
`ifndef TTSI_PARAMS_SVH
`define TTSI_PARAMS_SVH
// nibble positions inside an 8-bit timer word
`define TTSI_HI_MSB 7
`define TTSI_HI_LSB 4
`define TTSI_LO_MSB 3
`define TTSI_LO_LSB 0
// reset values
`define TTSI_NIB_RST 4'h0
`define TTSI_BYTE_RST 8'h00
// port-d test takes two cycles
`define TTSI_PORTD_CYCLES 2'h2
`endif

// [core/ttsi_pkg.sv]
package ttsi_pkg;
  typedef enum logic [3:0] {
    OP_NONE           = 4'h0,
    OP_LOAD_T1_LOW    = 4'h1,
    OP_LOAD_T1_HIGH   = 4'h2,
    OP_RELOAD_T1      = 4'h3,
    OP_LOAD_T2_LOW    = 4'h4,
    OP_LOAD_T2_HIGH   = 4'h5,
    OP_RELOAD_T2      = 4'h6,
    OP_B_TO_ACC       = 4'h7,
    OP_READ_T2        = 4'h8,
    OP_SKIP_MEM_BIT   = 4'h9,
    OP_SKIP_PORTD_BIT = 4'ha,
    OP_SERIAL_START   = 4'hb
  } ttsi_op_type;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_PORTD = 1'b1
  } ttsi_state_type;
endpackage : ttsi_pkg

// [core/ttsi_sync2.sv]
`timescale 1ns/1ps
// two-flop synchroniser for the port d pins
module ttsi_sync2 (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] d_in,
  output logic      [3:0] q_out
);
  logic [3:0] meta_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= 4'h0;
      q_out    <= 4'h0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : ttsi_sync2

// [dv/ttsi_exec_tb_top.sv]
`timescale 1ns/1ps
module ttsi_exec_tb_top;
  logic       clk_in, rst_n_in, op_valid_in;
  logic [3:0] op_code_in, acc_in, reg_b_in, mem_word_in, portd_pins_in;
  logic [1:0] bit_sel_in, index_y_in;
  logic [7:0] timer2_count_in;
  logic       acc_we_out, reg_b_we_out, t1_we, t2_we, skip_next_out;
  logic       busy_out, serial_start_out, ser_clr;
  logic [3:0] acc_out, reg_b_out;
  logic [7:0] t1_cnt, t1_r1, t1_r2, t2_cnt, t2_r1, t2_r2;
  int         mismatches = 0;
  int         cmp_count = 0;

  ttsi_exec dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .bit_sel_in(bit_sel_in), .index_y_in(index_y_in), .acc_in(acc_in),
    .reg_b_in(reg_b_in), .mem_word_in(mem_word_in),
    .timer2_count_in(timer2_count_in), .portd_pins_in(portd_pins_in),
    .acc_we_out(acc_we_out), .acc_out(acc_out),
    .reg_b_we_out(reg_b_we_out), .reg_b_out(reg_b_out),
    .timer1_count_we_out(t1_we), .timer1_count_out(t1_cnt),
    .timer1_first_reload_out(t1_r1), .timer1_second_reload_out(t1_r2),
    .timer2_count_we_out(t2_we), .timer2_count_out(t2_cnt),
    .timer2_first_reload_out(t2_r1), .timer2_second_reload_out(t2_r2),
    .skip_next_out(skip_next_out), .busy_out(busy_out),
    .serial_start_out(serial_start_out),
    .serial_request_flag_clr_out(ser_clr));

  always #12.5 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  // valid stays high so consecutive issues run back to back
  task automatic issue(input logic [3:0] op, input logic [3:0] a,
                       input logic [3:0] b);
    op_code_in = op;
    acc_in = a;
    reg_b_in = b;
    op_valid_in = 1'b1;
    @(posedge clk_in);
    #2;
  endtask : issue

  task automatic idle;
    op_valid_in = 1'b0;
    @(posedge clk_in);
    #2;
  endtask : idle

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////
  task automatic t_timer1;
    issue(ttsi_pkg::OP_LOAD_T1_LOW, 4'ha, 4'h5);
    chk(t1_we === 1'b1 && t1_cnt === 8'h5a
        && t1_r1 === 8'h5a, "t1 load");
    issue(ttsi_pkg::OP_LOAD_T1_HIGH, 4'h3, 4'hc);
    chk(t1_we === 1'b0 && t1_r2 === 8'hc3
        && t1_r1 === 8'h5a && t1_cnt === 8'h5a, "t1 high");
    issue(ttsi_pkg::OP_RELOAD_T1, 4'h0, 4'h0);
    chk(t1_we === 1'b1 && t1_cnt === 8'h5a, "t1 reload");
    idle();
    chk(t1_we === 1'b0, "t1 strobe held");
    $display("test timer1 done");
  endtask : t_timer1

  task automatic t_timer2;
    issue(ttsi_pkg::OP_LOAD_T2_LOW, 4'h7, 4'h1);
    chk(t2_we === 1'b1 && t2_cnt === 8'h17
        && t2_r1 === 8'h17, "t2 load");
    issue(ttsi_pkg::OP_LOAD_T2_HIGH, 4'he, 4'h9);
    chk(t2_we === 1'b0 && t2_r2 === 8'h9e
        && t2_r1 === 8'h17 && t2_cnt === 8'h17, "t2 high");
    issue(ttsi_pkg::OP_RELOAD_T2, 4'h0, 4'h0);
    chk(t2_we === 1'b1 && t2_cnt === 8'h17, "t2 reload");
    idle();
    chk(t2_we === 1'b0, "t2 strobe held");
    $display("test timer2 done");
  endtask : t_timer2

  task automatic t_transfer;
    timer2_count_in = 8'hd2;
    issue(ttsi_pkg::OP_B_TO_ACC, 4'h3, 4'hc);
    chk(reg_b_we_out === 1'b0 && acc_we_out === 1'b1
        && acc_out === 4'hc, "b to acc");
    issue(ttsi_pkg::OP_READ_T2, 4'h0, 4'h0);
    chk(reg_b_we_out === 1'b1 && reg_b_out === 4'hd
        && acc_we_out === 1'b1 && acc_out === 4'h2, "read t2");
    idle();
    $display("test transfer done");
  endtask : t_transfer

  // async reset in mid-run must clear every held value
  task automatic t_reset;
    rst_n_in = 1'b0;
    #1;
    chk(t1_r1 === 8'h00 && t1_r2 === 8'h00 && t1_cnt === 8'h00, "t1 rst");
    chk(t2_r1 === 8'h00 && t2_r2 === 8'h00 && t2_cnt === 8'h00, "t2 rst");
    chk(acc_out === 4'h0 && reg_b_out === 4'h0 && busy_out === 1'b0,
        "regs rst");
    @(posedge clk_in);
    #2;
    rst_n_in = 1'b1;
    $display("test reset done");
  endtask : t_reset

  task automatic t_memskip;
    for (int k = 0; k < 8; k++) begin
      bit_sel_in = k[1:0];
      mem_word_in = k[2] ? (4'h1 << k[1:0]) : ~(4'h1 << k[1:0]);
      issue(ttsi_pkg::OP_SKIP_MEM_BIT, 4'h0, 4'h0);
      chk(skip_next_out === ~k[2], "mem bit skip");
    end
    idle();
    $display("test memory skip done");
  endtask : t_memskip

  task automatic t_portd;
    portd_pins_in = 4'h5;
    repeat (3) @(posedge clk_in);
    #2;
    for (int y = 0; y < 4; y++) begin
      index_y_in = y[1:0];
      issue(ttsi_pkg::OP_SKIP_PORTD_BIT, 4'h1, 4'h2);
      chk(busy_out === 1'b1 && skip_next_out === 1'b0, "portd busy");
      // busy cycle: valid stays high with a new op that must be ignored, index already captured at issue
      op_code_in = ttsi_pkg::OP_B_TO_ACC;
      index_y_in = y[1:0] ^ 2'h1;
      @(posedge clk_in);
      #2;
      chk(busy_out === 1'b0 && acc_we_out === 1'b0 &&
          skip_next_out === ~portd_pins_in[y], "portd skip");
    end
    idle();
    $display("test portd skip done");
  endtask : t_portd

  task automatic t_serial;
    issue(ttsi_pkg::OP_SERIAL_START, 4'h0, 4'h0);
    chk(serial_start_out === 1'b1 && ser_clr === 1'b1, "serial start");
    idle();
    chk(serial_start_out === 1'b0 && ser_clr === 1'b0, "serial pulse");
    $display("test serial done");
  endtask : t_serial

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    op_valid_in = 1'b0;
    op_code_in = 4'h0;
    acc_in = 4'h0;
    reg_b_in = 4'h0;
    mem_word_in = 4'h0;
    bit_sel_in = 2'h0;
    index_y_in = 2'h0;
    timer2_count_in = 8'h00;
    portd_pins_in = 4'h0;
    repeat (12) @(posedge clk_in);
    #2;
    rst_n_in = 1'b1;
    chk(busy_out === 1'b0 && t1_r1 === 8'h00 && t2_r2 === 8'h00, "reset");
    t_timer1();
    t_timer2();
    t_transfer();
    t_reset();
    t_memskip();
    t_portd();
    t_serial();
    give_verdict();
  end

  // whole run needs about 50 cycles
  initial begin
    repeat (2000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end
endmodule : ttsi_exec_tb_top
